// ---- core/fcue_regs.vh ----
// Register map, command codes and state codes of the flash sequencer
`ifndef FCUE_REGS_VH
`define FCUE_REGS_VH

`define FCUE_ADDR_CTRL     12'hFF8
`define FCUE_ADDR_PSEL     12'hFF9
`define FCUE_ADDR_PROT     12'hFFA
`define FCUE_ADDR_STAT     12'hFFB

`define FCUE_PSEL_RESET    8'h00
`define FCUE_PROT_RESET    8'h00
`define FCUE_INFO_BIT      7
`define FCUE_INFO_BASE     7'h7F

`define FCUE_CMD_UNLOCK1   8'h73
`define FCUE_CMD_UNLOCK2   8'h8C
`define FCUE_CMD_PROTSEL   8'h5E
`define FCUE_CMD_MASS      8'h63
`define FCUE_CMD_PAGE      8'h95

`define FCUE_ST_LOCKED     3'h0
`define FCUE_ST_FIRST      3'h1
`define FCUE_ST_SECOND     3'h2
`define FCUE_ST_UNLOCKED   3'h3
`define FCUE_ST_PROTSEL    3'h4
`define FCUE_ST_PROG       3'h5
`define FCUE_ST_PERASE     3'h6
`define FCUE_ST_MERASE     3'h7

`define FCUE_CODE_LOCKED   6'h00
`define FCUE_CODE_FIRST    6'h01
`define FCUE_CODE_SECOND   6'h02
`define FCUE_CODE_UNLOCKED 6'h03
`define FCUE_CODE_PROTSEL  6'h04
`define FCUE_CODE_PROG     6'h08
`define FCUE_CODE_PERASE   6'h10
`define FCUE_CODE_MERASE   6'h20

`define FCUE_SYNC_W        27

`endif

// ---- core/fcue_core.v ----
// Flash controller unlock, page select, sector protect, erase and bypass
// How it works
// RULE1: Debugger writing the mass-erase code to control starts a whole-array erase.
// RULE2: During mass erase the CPU is stalled; clock and peripherals keep running.
// RULE3: Finished mass erase returns to locked and status shows the locked code.
// RULE4: Bypass mode routes the flash control signals straight from GPIO pins.
// RULE5: Debugger access ignores the flash write-protect option bit.
// RULE6: Debugger access lets program and erase pass protected sectors.
// RULE7: Debugger access allows programming at any address, not only the page.
// RULE8: Debugger access can write protection bits to one or zero.
// RULE9: Debugger access unlocks without the second page-select write.
// RULE10: Debugger access may write page select while unlocked.
// RULE11: Mass-erase command works only under debugger access, else it is ignored.
// RULE12: One page per unlock; another page needs the full unlock again.
// RULE13: Six-bit status codes: locked, first byte, second byte, unlocked, protect.
// RULE14: Status shows program, page erase or mass erase while they run.
// RULE15: Shared address writes page select unless unlocked and protect selected.
// RULE16: Pages are 512 bytes; page field gives address bits 15 to 9.
// RULE17: Page select bit 7 maps the information area at FE00H to FFFFH.
// RULE18: After first unlock byte and protect byte, shared write goes to protect.
// RULE19: Outside debugger access protection bits set only, never clear.
// RULE20: Status reads upper two bits as zero; writes to it do nothing.
// RULE21: Any out-of-order unlock byte returns to locked.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "fcue_regs.vh"

module fcue_core (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [11:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        dbg_access,
  input  wire        wp_option,
  input  wire        mem_wr,
  input  wire [15:0] mem_addr,
  input  wire [7:0]  mem_wdata,
  input  wire        flash_done,
  input  wire        pin_bypass,
  input  wire        pin_prog,
  input  wire        pin_erase,
  input  wire [15:0] pin_addr,
  input  wire [7:0]  pin_data,
  output reg         cpu_stall,
  output reg         flash_prog,
  output reg         flash_page_erase,
  output reg         flash_mass_erase,
  output reg         flash_info_sel,
  output reg  [15:0] flash_addr,
  output reg  [7:0]  flash_wdata,
  output reg         info_area_map_enable
);

  // Pin inputs pass two flops before use
  wire [`FCUE_SYNC_W-1:0] pin_raw;
  reg  [`FCUE_SYNC_W-1:0] sync1_q;
  reg  [`FCUE_SYNC_W-1:0] sync2_q;

  assign pin_raw = {pin_bypass, pin_prog, pin_erase,
                    pin_addr, pin_data};

  genvar gi;
  generate
    for (gi = 0; gi < `FCUE_SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire        byp_on;
  wire        byp_prog;
  wire        byp_erase;
  wire [15:0] byp_addr;
  wire [7:0]  byp_data;

  assign byp_on    = sync2_q[26];
  assign byp_prog  = sync2_q[25];
  assign byp_erase = sync2_q[24];
  assign byp_addr  = sync2_q[23:8];
  assign byp_data  = sync2_q[7:0];

  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg [7:0]  psel_q;
  reg [7:0]  psel_d;
  reg [7:0]  prot_q;
  reg [7:0]  prot_d;
  reg [5:0]  code;

  wire wr_ctrl;
  wire wr_psel;
  wire rd_any;
  wire [6:0] page;

  assign wr_ctrl = reg_wr && (reg_addr == `FCUE_ADDR_CTRL);
  assign wr_psel = reg_wr && (reg_addr == `FCUE_ADDR_PSEL);
  assign rd_any  = reg_rd;
  assign page    = psel_q[6:0];

  // Sector index from 512-byte page; pages above 7 have no sector
  wire       pg_sect_ok;
  wire       pg_prot;
  wire       mem_sect_ok;
  wire       mem_prot;
  wire       mem_in_page;
  wire       may_write;

  assign pg_sect_ok  = (page[6:3] == 4'h0);
  assign pg_prot     = pg_sect_ok && prot_q[page[2:0]];
  assign mem_sect_ok = (mem_addr[15:12] == 4'h0);
  assign mem_prot    = mem_sect_ok && prot_q[mem_addr[11:9]];
  assign mem_in_page = (mem_addr[15:9] == page); // [RULE16]

  // Debugger overrides the option bit and sector protection
  assign may_write = dbg_access || !wp_option; // [RULE5]

  wire prog_ok;
  wire perase_ok;

  assign prog_ok = may_write
                && (dbg_access || mem_in_page) // [RULE7] [RULE12]
                && (dbg_access || !mem_prot);  // [RULE6]
  assign perase_ok = may_write
                  && (dbg_access || !pg_prot); // [RULE6]

  wire op_busy;
  assign op_busy = (state_q == `FCUE_ST_PROG)
                || (state_q == `FCUE_ST_PERASE)
                || (state_q == `FCUE_ST_MERASE);

  // Sequencer next state and shared register updates
  always @* begin
    state_d = state_q;
    psel_d  = psel_q;
    prot_d  = prot_q;
    case (state_q)
      `FCUE_ST_LOCKED: begin
        if (wr_psel) begin
          psel_d = reg_wdata; // [RULE15]
        end
        if (wr_ctrl) begin
          if (reg_wdata == `FCUE_CMD_UNLOCK1) begin
            state_d = `FCUE_ST_FIRST;
          end
        end
      end
      `FCUE_ST_FIRST: begin
        if (wr_psel) begin
          psel_d  = reg_wdata;
          state_d = `FCUE_ST_LOCKED; // [RULE21]
        end else if (wr_ctrl) begin
          if (reg_wdata == `FCUE_CMD_UNLOCK2) begin
            if (dbg_access) begin
              state_d = `FCUE_ST_UNLOCKED; // [RULE9]
            end else begin
              state_d = `FCUE_ST_SECOND;
            end
          end else if (reg_wdata == `FCUE_CMD_PROTSEL) begin
            state_d = `FCUE_ST_PROTSEL; // [RULE18]
          end else begin
            state_d = `FCUE_ST_LOCKED; // [RULE21]
          end
        end
      end
      `FCUE_ST_SECOND: begin
        // Second page write must repeat the page already selected
        if (wr_psel) begin
          if (reg_wdata == psel_q) begin
            state_d = `FCUE_ST_UNLOCKED;
          end else begin
            psel_d  = reg_wdata;
            state_d = `FCUE_ST_LOCKED; // [RULE21]
          end
        end else if (wr_ctrl) begin
          state_d = `FCUE_ST_LOCKED; // [RULE21]
        end
      end
      `FCUE_ST_UNLOCKED: begin
        if (wr_psel && dbg_access) begin
          psel_d = reg_wdata; // [RULE10]
        end
        if (wr_ctrl) begin
          if (reg_wdata == `FCUE_CMD_PROTSEL) begin
            state_d = `FCUE_ST_PROTSEL; // [RULE15]
          end else if (reg_wdata == `FCUE_CMD_PAGE
                       && perase_ok) begin
            state_d = `FCUE_ST_PERASE;
          end else if (reg_wdata == `FCUE_CMD_MASS
                       && dbg_access) begin
            state_d = `FCUE_ST_MERASE; // [RULE1] [RULE11]
          end else begin
            state_d = `FCUE_ST_LOCKED;
          end
        end else if (mem_wr && prog_ok) begin
          state_d = `FCUE_ST_PROG;
        end
      end
      `FCUE_ST_PROTSEL: begin
        if (wr_psel) begin
          if (dbg_access) begin
            prot_d = reg_wdata; // [RULE8]
          end else begin
            prot_d = prot_q | reg_wdata; // [RULE19]
          end
          state_d = `FCUE_ST_LOCKED;
        end else if (wr_ctrl) begin
          state_d = `FCUE_ST_LOCKED; // [RULE21]
        end
      end
      `FCUE_ST_PROG: begin
        // Stay open on the same page for further bytes
        if (flash_done) begin
          state_d = `FCUE_ST_UNLOCKED; // [RULE12]
        end
      end
      `FCUE_ST_PERASE: begin
        if (flash_done) begin
          state_d = `FCUE_ST_LOCKED; // [RULE12]
        end
      end
      `FCUE_ST_MERASE: begin
        if (flash_done) begin
          state_d = `FCUE_ST_LOCKED; // [RULE3]
        end
      end
      default: begin
        state_d = `FCUE_ST_LOCKED;
      end
    endcase
    // Mass erase from the debugger is accepted in any idle state
    if (wr_ctrl && dbg_access && !op_busy
        && reg_wdata == `FCUE_CMD_MASS) begin
      state_d = `FCUE_ST_MERASE; // [RULE1] [RULE11]
    end
  end

  always @* begin
    case (state_q)
      `FCUE_ST_LOCKED:   code = `FCUE_CODE_LOCKED; // [RULE13]
      `FCUE_ST_FIRST:    code = `FCUE_CODE_FIRST;
      `FCUE_ST_SECOND:   code = `FCUE_CODE_SECOND;
      `FCUE_ST_UNLOCKED: code = `FCUE_CODE_UNLOCKED;
      `FCUE_ST_PROTSEL:  code = `FCUE_CODE_PROTSEL;
      `FCUE_ST_PROG:     code = `FCUE_CODE_PROG;   // [RULE14]
      `FCUE_ST_PERASE:   code = `FCUE_CODE_PERASE; // [RULE14]
      `FCUE_ST_MERASE:   code = `FCUE_CODE_MERASE; // [RULE14]
      default:           code = `FCUE_CODE_LOCKED;
    endcase
  end

  wire start_prog;
  wire start_perase;
  wire start_merase;

  assign start_prog   = (state_d == `FCUE_ST_PROG)
                     && (state_q != `FCUE_ST_PROG);
  assign start_perase = (state_d == `FCUE_ST_PERASE)
                     && (state_q != `FCUE_ST_PERASE);
  assign start_merase = (state_d == `FCUE_ST_MERASE)
                     && (state_q != `FCUE_ST_MERASE);

  wire mem_info;
  assign mem_info = psel_q[`FCUE_INFO_BIT]
                 && (mem_addr[15:9] == `FCUE_INFO_BASE); // [RULE17]

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= `FCUE_ST_LOCKED;
      psel_q  <= `FCUE_PSEL_RESET;
      prot_q  <= `FCUE_PROT_RESET;
    end else begin
      state_q <= state_d;
      psel_q  <= psel_d;
      prot_q  <= prot_d;
    end
  end

  // Read data stands one cycle after the strobe; status is read-only
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (rd_any) begin
      case (reg_addr)
        `FCUE_ADDR_STAT: reg_rdata <= {2'b00, code}; // [RULE20]
        `FCUE_ADDR_PSEL: reg_rdata <= psel_q;
        `FCUE_ADDR_PROT: reg_rdata <= prot_q;
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Flash strobes are one-cycle pulses; bypass hands them to the pins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flash_prog       <= 1'b0;
      flash_page_erase <= 1'b0;
      flash_mass_erase <= 1'b0;
      flash_info_sel   <= 1'b0;
      flash_addr       <= 16'h0000;
      flash_wdata      <= 8'h00;
    end else if (byp_on) begin
      flash_prog       <= byp_prog;  // [RULE4]
      flash_page_erase <= byp_erase; // [RULE4]
      flash_mass_erase <= 1'b0;
      flash_info_sel   <= 1'b0;
      flash_addr       <= byp_addr;  // [RULE4]
      flash_wdata      <= byp_data;
    end else begin
      flash_prog       <= start_prog;
      flash_page_erase <= start_perase;
      flash_mass_erase <= start_merase;
      if (start_prog) begin
        flash_addr     <= mem_addr;
        flash_wdata    <= mem_wdata;
        flash_info_sel <= mem_info; // [RULE17]
      end else if (start_perase) begin
        flash_addr     <= {page, 9'h000}; // [RULE16]
        flash_wdata    <= 8'h00;
        flash_info_sel <= psel_q[`FCUE_INFO_BIT]
                       && (page == `FCUE_INFO_BASE);
      end else begin
        // Select travels with its start pulse only, never left stale
        flash_info_sel <= 1'b0;
      end
    end
  end

  // Stall covers the whole mass erase, including its start cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cpu_stall            <= 1'b0;
      info_area_map_enable <= 1'b0;
    end else begin
      cpu_stall <= (state_d == `FCUE_ST_MERASE); // [RULE2]
      info_area_map_enable <= psel_d[`FCUE_INFO_BIT]; // [RULE17]
    end
  end

endmodule

// ---- dv/fcue_flash_model.sv ----
// Flash array model: answers each start pulse with a done pulse
`timescale 1ns/1ns
module fcue_flash_model (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [3:0] lat,
  input  wire       start,
  output reg        flash_done
);
  reg [3:0] cnt_q;
  // Latency is set by the bench, so fast and slow arrays both get used
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt_q == 4'h1);
      if (start)
        cnt_q <= lat;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// ---- dv/fcue_monitor.sv ----
// Port checker for the flash sequencer
`timescale 1ns/1ns
`include "fcue_regs.vh"
module fcue_monitor (
  input wire        clk_sys,
  input wire        rst,
  input wire [11:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        dbg_access,
  input wire        pin_bypass,
  input wire        pin_prog,
  input wire [15:0] pin_addr,
  input wire        flash_done,
  input wire        cpu_stall,
  input wire        flash_prog,
  input wire        flash_page_erase,
  input wire        flash_mass_erase,
  input wire        flash_info_sel,
  input wire [15:0] flash_addr,
  input wire        info_area_map_enable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg  [2:0] byp_q;
  // Bypass takes three edges to reach the outputs
  wire       quiet = ~|byp_q & ~pin_bypass;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      byp_q <= 3'h0;
    else
      byp_q <= {byp_q[1:0], pin_bypass};
  end
  AST_MASS_CAUSE: assert property (flash_mass_erase |-> $past(reg_wr && dbg_access &&
    reg_addr == `FCUE_ADDR_CTRL && reg_wdata == `FCUE_CMD_MASS)) else $error("mass erase without command");
  AST_STALL_START: assert property (flash_mass_erase |-> cpu_stall) else $error("no stall");
  AST_STALL_CAUSE: assert property ($rose(cpu_stall) |-> flash_mass_erase) else $error("stray stall");
  AST_STALL_END: assert property (cpu_stall && flash_done |=> !cpu_stall) else $error("stall held");
  AST_STAT_RSVD: assert property (reg_rd && reg_addr == `FCUE_ADDR_STAT |=> reg_rdata[7:6] == 2'b00)
    else $error("status top bits set");
  AST_PAGE_ALIGN: assert property (quiet && flash_page_erase |-> flash_addr[8:0] == 9'h000)
    else $error("erase address not page aligned");
  AST_INFO_SEL: assert property (quiet && flash_info_sel |-> info_area_map_enable &&
    flash_addr[15:9] == `FCUE_INFO_BASE) else $error("info select outside info area");
  AST_BYPASS: assert property (&byp_q && pin_bypass |-> flash_prog == $past(pin_prog, 3) &&
    flash_addr == $past(pin_addr, 3)) else $error("bypass path wrong");
  AST_ONE_OP: assert property (quiet |-> $onehot0({flash_prog, flash_page_erase, flash_mass_erase}))
    else $error("two operations at once");
  COV_MASS: cover property (flash_mass_erase ##[1:20] flash_done);
  COV_PAGE: cover property (quiet && flash_page_erase);
  COV_BYP: cover property (&byp_q && flash_prog);
endmodule
bind fcue_core fcue_monitor u_mon (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .dbg_access, .pin_bypass, .pin_prog, .pin_addr, .flash_done, .cpu_stall, .flash_prog, .flash_page_erase,
  .flash_mass_erase, .flash_info_sel, .flash_addr, .info_area_map_enable);

// ---- dv/flash_controller_unlock_erase_tb.sv ----
// Self-checking bench for the flash sequencer
`timescale 1ns/1ns
`include "fcue_regs.vh"
module flash_controller_unlock_erase_tb;
  reg         clk_sys, rst, reg_wr, reg_rd, dbg_access, wp_option, mem_wr, pin_bypass, pin_prog, pin_erase;
  reg  [11:0] reg_addr;
  reg  [7:0]  reg_wdata, mem_wdata, pin_data;
  reg  [15:0] mem_addr, pin_addr;
  reg  [3:0]  lat;
  wire [7:0]  reg_rdata, flash_wdata;
  wire [15:0] flash_addr;
  wire        flash_done, cpu_stall, flash_prog, flash_page_erase, flash_mass_erase, flash_info_sel, info_map;
  integer     err_total, n_checks, cyc, i;
  fcue_core DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dbg_access,
    .wp_option, .mem_wr, .mem_addr, .mem_wdata, .flash_done, .pin_bypass, .pin_prog, .pin_erase, .pin_addr,
    .pin_data, .cpu_stall, .flash_prog, .flash_page_erase, .flash_mass_erase, .flash_info_sel, .flash_addr,
    .flash_wdata, .info_area_map_enable(info_map));
  fcue_flash_model u_flash (.clk_sys, .rst, .lat, .flash_done,
    .start(flash_prog | flash_page_erase | flash_mass_erase));
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Every driver changes inputs only at a rising edge, checks look at the falling one
  task wr(input [11:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input [11:0] a, input [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys) chk("rdata", reg_rdata, e);
  endtask
  task st(input [5:0] c);
    rd(`FCUE_ADDR_STAT, {2'b00, c});
  endtask
  task mw(input [15:0] a);
    @(posedge clk_sys);
    mem_addr <= a; mem_wdata <= 8'hA5; mem_wr <= 1'b1;
    @(posedge clk_sys);
    mem_wr <= 1'b0;
  endtask
  task ops(input [2:0] e, input [15:0] ad);
    @(negedge clk_sys) chk("ops", {flash_prog, flash_page_erase, flash_mass_erase}, e);
    if (e[2] | e[1]) chk("faddr", flash_addr, ad);
  endtask
  task wd;
    i = 0;
    while (flash_done !== 1'b1 && i < 20) begin
      @(negedge clk_sys);
      i = i + 1;
    end
    chk("done", flash_done, 1);
  endtask
  task unl(input [7:0] p);
    wr(`FCUE_ADDR_PSEL, p); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1);
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK2); wr(`FCUE_ADDR_PSEL, p);
  endtask
  task t_reset;
    rd(`FCUE_ADDR_PSEL, 8'h00); rd(`FCUE_ADDR_PROT, 8'h00); rd(`FCUE_ADDR_CTRL, 8'h00); rd(12'h123, 8'h00);
    wr(`FCUE_ADDR_STAT, 8'hFF); st(`FCUE_CODE_LOCKED);
    $display("test reset done");
  endtask
  task t_normal;
    wr(`FCUE_ADDR_PSEL, 8'h02); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1); st(`FCUE_CODE_FIRST);
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK2); st(`FCUE_CODE_SECOND);
    wr(`FCUE_ADDR_PSEL, 8'h02); st(`FCUE_CODE_UNLOCKED);
    mw(16'h0405); ops(3'h4, 16'h0405); chk("fdata", flash_wdata, 8'hA5);
    st(`FCUE_CODE_PROG); wd; st(`FCUE_CODE_UNLOCKED);
    mw(16'h0605); ops(3'h0, 0);
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_PAGE); ops(3'h2, 16'h0400); st(`FCUE_CODE_PERASE);
    wd; st(`FCUE_CODE_LOCKED);
    @(posedge clk_sys); wp_option <= 1'b1; unl(8'h02); mw(16'h0405); ops(3'h0, 0);
    @(posedge clk_sys); wp_option <= 1'b0; wr(`FCUE_ADDR_CTRL, 8'h00); st(`FCUE_CODE_LOCKED);
    $display("test normal done");
  endtask
  task t_badseq;
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1); wr(`FCUE_ADDR_CTRL, 8'h55); st(`FCUE_CODE_LOCKED);
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK2);
    wr(`FCUE_ADDR_PSEL, 8'h03); st(`FCUE_CODE_LOCKED);
    wr(`FCUE_ADDR_PSEL, 8'h80); @(negedge clk_sys) chk("info", info_map, 1);
    wr(`FCUE_ADDR_PSEL, 8'h00); @(negedge clk_sys) chk("info", info_map, 0);
    $display("test sequence done");
  endtask
  task t_protect;
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_PROTSEL);
    st(`FCUE_CODE_PROTSEL); wr(`FCUE_ADDR_PSEL, 8'h04); rd(`FCUE_ADDR_PROT, 8'h04);
    rd(`FCUE_ADDR_PSEL, 8'h00); st(`FCUE_CODE_LOCKED);
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_PROTSEL);
    wr(`FCUE_ADDR_PSEL, 8'h00); rd(`FCUE_ADDR_PROT, 8'h04);
    unl(8'h02); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_PAGE); ops(3'h0, 0); st(`FCUE_CODE_LOCKED);
    $display("test protect done");
  endtask
  task t_debug;
    @(posedge clk_sys); dbg_access <= 1'b1; lat <= 4'hC;
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK2);
    st(`FCUE_CODE_UNLOCKED);
    wr(`FCUE_ADDR_PSEL, 8'h03); rd(`FCUE_ADDR_PSEL, 8'h03); wr(`FCUE_ADDR_PSEL, 8'h82);
    @(posedge clk_sys); wp_option <= 1'b1; mw(16'h1234); ops(3'h4, 16'h1234);
    chk("isel", flash_info_sel, 0); wd; mw(16'hFE10); ops(3'h4, 16'hFE10);
    chk("isel", flash_info_sel, 1); wd; @(posedge clk_sys); wp_option <= 1'b0;
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_PAGE); ops(3'h2, 16'h0400); wd; st(`FCUE_CODE_LOCKED);
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_UNLOCK1); wr(`FCUE_ADDR_CTRL, `FCUE_CMD_PROTSEL);
    wr(`FCUE_ADDR_PSEL, 8'h00); rd(`FCUE_ADDR_PROT, 8'h00);
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_MASS); ops(3'h1, 16'h0000); chk("stall", cpu_stall, 1);
    st(`FCUE_CODE_MERASE); chk("stall", cpu_stall, 1);
    wd; @(negedge clk_sys) chk("stall", cpu_stall, 0);
    st(`FCUE_CODE_LOCKED);
    @(posedge clk_sys); dbg_access <= 1'b0;
    wr(`FCUE_ADDR_CTRL, `FCUE_CMD_MASS); ops(3'h0, 0); st(`FCUE_CODE_LOCKED);
    $display("test debugger done");
  endtask
  task t_bypass;
    // External programmer drives the raw strobes itself
    @(posedge clk_sys);
    pin_bypass <= 1'b1; pin_prog <= 1'b1; pin_erase <= 1'b1; pin_addr <= 16'h1234; pin_data <= 8'h5A;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) chk("bprog", flash_prog, 1);
    chk("berase", flash_page_erase, 1); chk("baddr", flash_addr, 16'h1234); chk("bdata", flash_wdata, 16'h5A);
    @(posedge clk_sys); pin_prog <= 1'b0; pin_erase <= 1'b0; pin_bypass <= 1'b0;
    repeat (20) @(posedge clk_sys);
    $display("test bypass done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  initial begin
    err_total = 0; n_checks = 0; cyc = 0;
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 12'h000; reg_wdata = 8'h00; lat = 4'h6;
    dbg_access = 1'b0; wp_option = 1'b0; mem_wr = 1'b0; mem_addr = 16'h0000; mem_wdata = 8'h00;
    pin_bypass = 1'b0; pin_prog = 1'b0; pin_erase = 1'b0; pin_addr = 16'h0000; pin_data = 8'h00;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset; t_normal; t_badseq; t_protect; t_debug; t_bypass;
    wrap_up;
  end
endmodule
